// ### swam_pkg.sv
// swam_pkg: constants, register map and types for the servo warning/alarm manager
// assumes: a single 250 MHz clock domain; no other package is needed
package swam_pkg;

  // ----
  // clock and time base
  // ----
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned FAN_STOP_MS   = 1000;                            // fan stopped this long -> warning
  localparam int unsigned FAN_STOP_CYC  = (CLK_HZ / 1000) * FAN_STOP_MS;
  localparam int unsigned ONE_SEC_CYC   = CLK_HZ;                          // cycles in one second of hold time

  // ----
  // warning indices (bit positions of the warning vector)
  // ----
  localparam int NWARN   = 10;
  localparam int W_OVL   = 0;   // A0 overload
  localparam int W_REGEN = 1;   // A1 regeneration
  localparam int W_BATT  = 2;   // A2 battery
  localparam int W_FAN   = 3;   // A3 fan
  localparam int W_ENC   = 4;   // A4 encoder comms
  localparam int W_ENCT  = 5;   // A5 encoder temperature
  localparam int W_VIB   = 6;   // A6 vibration
  localparam int W_LIFE  = 7;   // A7 life expectancy
  localparam int W_XENC  = 8;   // A8 external encoder warning
  localparam int W_XCOM  = 9;   // A9 external encoder comms

  // mask bit position of each warning inside warn_mask_bits
  localparam logic [3:0] MASK_POS [NWARN] = '{4'h7, 4'h5, 4'h0, 4'h6, 4'h4, 4'h3, 4'h9, 4'h2, 4'h8, 4'ha};
  // selection that routes every warning
  localparam logic [3:0] SEL_ALL = 4'h0;

  // threshold: 85 percent, in per-mille of the protection level
  localparam logic [9:0] LOAD_WARN_PM  = 10'h352;   // 850
  localparam logic [11:0] BATT_WARN_MV = 12'hc80;   // 3200 mV

  // hold time codes: 0 = no time limit, 1..10 = seconds
  localparam logic [3:0] HOLD_NOLIMIT = 4'h0;
  localparam logic [3:0] HOLD_MAX_S   = 4'ha;

  // ----
  // register map (word indices, word index = addr[5:2])
  // ----
  localparam logic [3:0] REG_SEL1    = 4'h0;   // warn_out1_select
  localparam logic [3:0] REG_SEL2    = 4'h1;   // warn_out2_select
  localparam logic [3:0] REG_HOLD    = 4'h2;   // warn_latch_hold_time
  localparam logic [3:0] REG_MASK    = 4'h3;   // warn_mask_bits
  localparam logic [3:0] REG_WSTAT   = 4'h4;   // live and held warnings
  localparam logic [3:0] REG_ALARM   = 4'h5;   // alarm state, code, attributes
  localparam logic [3:0] REG_SNAP    = 4'h6;   // status snapshot at alarm entry
  localparam logic [3:0] REG_CMD     = 4'h7;   // service tool clear command
  localparam logic [3:0] REG_CNTLIM  = 4'h8;   // comm-error count limits
  localparam logic [3:0] REG_SETVAL  = 4'h9;   // temperature and life limits
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  // reset values
  localparam logic [3:0]  RST_SEL    = 4'h0;
  localparam logic [3:0]  RST_HOLD   = 4'h1;
  localparam logic [10:0] RST_MASK   = 11'h000;
  localparam logic [7:0]  RST_CNTLIM = 8'h08;
  localparam logic [7:0]  RST_TEMP   = 8'h78;
  localparam logic [7:0]  RST_LIFE   = 8'h0a;

  // alarm attribute bit positions
  localparam int ATTR_HIST  = 0;
  localparam int ATTR_CLR   = 1;
  localparam int ATTR_IMMED = 2;

  // alarm states
  typedef enum logic [1:0] {
    ALM_IDLE  = 2'b00,
    ALM_STOP  = 2'b01,
    ALM_HOLD  = 2'b10
  } swam_alm_e;

  // clip a seconds code to at most HOLD_MAX_S
  function automatic logic [3:0] swam_hold_clip(input logic [3:0] code);
    swam_hold_clip = (code > HOLD_MAX_S) ? HOLD_MAX_S : code;
  endfunction

endpackage

// ### swam_cfg_if.sv
// swam_cfg_if: configuration and warning state shared between top and latch bank
// assumes: driven by the register block in the top module
`timescale 1ns/1ns
interface swam_cfg_if;
  import swam_pkg::*;
  logic [3:0]       hold_time;
  logic [NWARN-1:0] raw;
  logic [NWARN-1:0] active;
  logic             clear;
  modport ctl (output hold_time, output raw, output clear, input active);
  modport bank (input hold_time, input raw, input clear, output active);
endinterface

// ### swam_latch_bank.sv
// swam_latch_bank: per-warning latch with programmable hold time
// assumes: one pulse of the second tick per second from the top module
`timescale 1ns/1ns
module swam_latch_bank
  import swam_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic sec_tick_i,
  swam_cfg_if.bank  cfg
);

  // ----
  // per-warning hold state
  // ----
  logic [NWARN-1:0] held;
  logic [3:0]       secs [NWARN];
  logic [3:0]       hold_lim;
  logic [NWARN-1:0] no_limit;

  assign hold_lim = swam_hold_clip(cfg.hold_time);

  // battery and life warnings never time out
  always_comb begin
    no_limit         = '0;
    no_limit[W_BATT] = 1'b1;
    no_limit[W_LIFE] = 1'b1;
    if (cfg.hold_time == HOLD_NOLIMIT) begin
      no_limit = '1;
    end
  end

  assign cfg.active = cfg.raw | held;

  // latch on rise, count seconds, drop once cause gone and time served
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < NWARN; i++) begin
      if (rst_i) begin
        held[i] <= 1'b0;
        secs[i] <= 4'h0;
      end else if (cfg.raw[i] && !held[i]) begin
        held[i] <= 1'b1;
        secs[i] <= 4'h0;
      end else if (held[i] && cfg.clear && !cfg.raw[i]) begin
        held[i] <= 1'b0;
      end else if (held[i]) begin
        if (sec_tick_i && secs[i] <= hold_lim) begin           // hold_lim+1 ticks: never early
          secs[i] <= secs[i] + 4'h1;
        end
        if (!cfg.raw[i] && !no_limit[i] && secs[i] > hold_lim) begin
          held[i] <= 1'b0;
        end
      end
    end
  end

endmodule

// ### swam_alarm_seq.sv
// swam_alarm_seq: alarm entry, stop selection, clearing and status snapshot
// assumes: alarm inputs already synchronised to clock_i
`timescale 1ns/1ns
module swam_alarm_seq
  import swam_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        err_i,
  input  wire logic [7:0]  err_code_i,
  input  wire logic [2:0]  err_attr_i,
  input  wire logic [15:0] status_i,
  input  wire logic        clr_req_i,
  input  wire logic        stop_done_i,
  output logic             alarm_o,
  output logic             pwr_off_o,
  output logic             immed_stop_o,
  output logic             seq_stop_o,
  output logic [7:0]       code_o,
  output logic [2:0]       attr_o,
  output logic [15:0]      snap_o,
  output logic             hist_o
);

  // ----
  // state machine
  // ----
  swam_alm_e state;
  swam_alm_e next_state;
  logic [15:0] prev_status;
  logic        clr_ok;

  assign clr_ok = clr_req_i && attr_o[ATTR_CLR];

  always_comb begin
    next_state = state;
    case (state)
      ALM_IDLE: begin
        if (err_i) next_state = ALM_STOP;
      end
      ALM_STOP: begin
        if (stop_done_i || attr_o[ATTR_IMMED]) next_state = ALM_HOLD;
      end
      ALM_HOLD: begin
        if (clr_ok && !err_i) next_state = ALM_IDLE;
      end
      default: next_state = ALM_IDLE;
    endcase
  end

  // state, code capture and snapshot of the previous cycle's status
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state       <= ALM_IDLE;
      prev_status <= '0;
      snap_o      <= '0;
      code_o      <= '0;
      attr_o      <= '0;
      hist_o      <= 1'b0;
    end else begin
      state       <= next_state;
      prev_status <= status_i;
      hist_o      <= 1'b0;
      if (state == ALM_IDLE && err_i) begin
        snap_o <= prev_status;
        code_o <= err_code_i;
        attr_o <= err_attr_i;
        hist_o <= err_attr_i[ATTR_HIST];
      end
    end
  end

  // outputs follow the state; run resumes as soon as the alarm leaves
  assign alarm_o      = (state != ALM_IDLE);
  assign pwr_off_o    = (state == ALM_HOLD) || (state == ALM_STOP && attr_o[ATTR_IMMED]);
  assign immed_stop_o = (state == ALM_STOP) && attr_o[ATTR_IMMED];
  assign seq_stop_o   = (state == ALM_STOP) && !attr_o[ATTR_IMMED];

endmodule

// ### swam_top.sv
// swam_top: servo warning and alarm manager with Avalon-MM register slave
// assumes: one 250 MHz clock; pin inputs are asynchronous and synchronised here
//
// How it works
// - warnings are raised at early thresholds before the protective alarm trips.
// - a latched warning drops after its cause clears and the hold time expires.
// - the alarm clear request clears held warnings early.
// - hold time is 1 to 10 seconds, or zero meaning no time limit.
// - the battery and life warnings are always held with no time limit.
// - two warning lines, each with its own selection register.
// - selection zero routes all warnings; software writes only listed values.
// - each warning has a mask bit; one suppresses detection.
// - overload warning at 85 percent load; select 1, mask bit 7.
// - regeneration warning at 85 percent; select 2, mask bit 5.
// - battery warning at 3.2 V or less; select 3, mask bit 0.
// - fan warning after fan stopped one second; select 4, mask bit 6.
// - encoder comms warning when error run exceeds limit; select 5, bit 4.
// - external encoder warning input; select 9, mask bit 8.
// - on error, assert alarm line, switch off power stage, show code.
// - clear by reset input, power cycle or service command; some need power cycle.
// - run resumes at once when alarm clears; host drops run first.
// - status from just before the alarm is captured for readout.
// - each alarm's immediate-stop attribute picks immediate or sequenced stop.
// - alarms carry history, clearable and immediate-stop attributes.
`timescale 1ns/1ns
module swam_top
  import swam_pkg::*;
#(
  parameter int unsigned SEC_CYC = ONE_SEC_CYC,
  parameter int unsigned FAN_CYC = FAN_STOP_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // monitored quantities (same clock)
  input  wire logic [9:0]  load_pm_i,
  input  wire logic [9:0]  regen_pm_i,
  input  wire logic [11:0] batt_mv_i,
  input  wire logic [7:0]  enc_temp_i,
  input  wire logic [7:0]  life_left_i,
  input  wire logic        enc_err_i,
  input  wire logic        enc_frame_i,
  input  wire logic        xenc_err_i,
  input  wire logic        xenc_frame_i,
  input  wire logic        vib_i,
  // asynchronous pins
  input  wire logic        fan_stopped_i,
  input  wire logic        xenc_warn_i,
  input  wire logic        alarm_reset_i,
  // alarm source and drive status
  input  wire logic        err_i,
  input  wire logic [7:0]  err_code_i,
  input  wire logic [2:0]  err_attr_i,
  input  wire logic [15:0] status_i,
  input  wire logic        stop_done_i,
  output logic             warning_line_one_o,
  output logic             warning_line_two_o,
  output logic             alarm_output_line_o,
  output logic             pwr_off_o,
  output logic             immed_stop_o,
  output logic             seq_stop_o,
  output logic [7:0]       alarm_code_o,
  output logic             hist_rec_o
);

  // ----
  // pin synchronisers
  // ----
  logic [2:0] pin_m;
  logic [2:0] pin_s;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_m <= '0;
      pin_s <= '0;
    end else begin
      pin_m <= {alarm_reset_i, xenc_warn_i, fan_stopped_i};
      pin_s <= pin_m;
    end
  end
  logic fan_stop_s;
  logic xenc_warn_s;
  logic rst_req_s;
  assign fan_stop_s  = pin_s[0];
  assign xenc_warn_s = pin_s[1];
  assign rst_req_s   = pin_s[2];

  // ----
  // configuration registers
  // ----
  logic [3:0]  sel1;
  logic [3:0]  sel2;
  logic [3:0]  hold_time;
  logic [10:0] mask;
  logic [7:0]  enc_lim;
  logic [7:0]  xenc_lim;
  logic [7:0]  temp_lim;
  logic [7:0]  life_lim;
  logic        tool_clr;

  logic [3:0] widx;
  logic       wr_en;
  logic       rd_en;
  logic       rd_ack;
  assign widx  = avs_address_i[5:2];
  assign wr_en = avs_write_i && avs_byteenable_i[0];
  assign rd_en = avs_read_i && !rd_ack;

  // writes take effect in the cycle with waitrequest low
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sel1      <= RST_SEL;
      sel2      <= RST_SEL;
      hold_time <= RST_HOLD;
      mask      <= RST_MASK;
      enc_lim   <= RST_CNTLIM;
      xenc_lim  <= RST_CNTLIM;
      temp_lim  <= RST_TEMP;
      life_lim  <= RST_LIFE;
      tool_clr  <= 1'b0;
    end else begin
      tool_clr <= wr_en && widx == REG_CMD && avs_writedata_i[0];
      if (wr_en && widx == REG_SEL1) sel1 <= avs_writedata_i[3:0];
      if (wr_en && widx == REG_SEL2) sel2 <= avs_writedata_i[3:0];
      if (wr_en && widx == REG_HOLD) hold_time <= swam_hold_clip(avs_writedata_i[3:0]);
      if (avs_write_i && widx == REG_MASK) begin
        if (avs_byteenable_i[0]) mask[7:0]  <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1]) mask[10:8] <= avs_writedata_i[10:8];
      end
      if (wr_en && widx == REG_CNTLIM) begin
        enc_lim  <= avs_writedata_i[7:0];
      end
      if (avs_write_i && avs_byteenable_i[1] && widx == REG_CNTLIM) xenc_lim <= avs_writedata_i[15:8];
      if (wr_en && widx == REG_SETVAL) temp_lim <= avs_writedata_i[7:0];
      if (avs_write_i && avs_byteenable_i[1] && widx == REG_SETVAL) life_lim <= avs_writedata_i[15:8];
    end
  end

  // ----
  // warning detection
  // ----
  logic [31:0] fan_cnt;
  logic [7:0]  enc_run;
  logic [7:0]  xenc_run;
  logic [31:0] sec_cnt;
  logic        sec_tick;

  // fan stop timer, comm error run counters and second tick
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fan_cnt  <= '0;
      enc_run  <= '0;
      xenc_run <= '0;
      sec_cnt  <= '0;
      sec_tick <= 1'b0;
    end else begin
      if (!fan_stop_s) fan_cnt <= '0;
      else if (fan_cnt < FAN_CYC) fan_cnt <= fan_cnt + 32'h1;
      if (enc_frame_i) enc_run <= enc_err_i ? (enc_run == 8'hff ? enc_run : enc_run + 8'h1) : 8'h0;
      if (xenc_frame_i) xenc_run <= xenc_err_i ? (xenc_run == 8'hff ? xenc_run : xenc_run + 8'h1) : 8'h0;
      sec_tick <= (sec_cnt == SEC_CYC - 1);
      sec_cnt  <= (sec_cnt == SEC_CYC - 1) ? 32'h0 : sec_cnt + 32'h1;
    end
  end

  logic [NWARN-1:0] detect;
  logic [NWARN-1:0] raw;
  assign detect[W_OVL]   = load_pm_i  >= LOAD_WARN_PM;
  assign detect[W_REGEN] = regen_pm_i >= LOAD_WARN_PM;
  assign detect[W_BATT]  = batt_mv_i  <= BATT_WARN_MV;
  assign detect[W_FAN]   = fan_cnt >= FAN_CYC;
  assign detect[W_ENC]   = enc_run > enc_lim;
  assign detect[W_ENCT]  = enc_temp_i > temp_lim;
  assign detect[W_VIB]   = vib_i;
  assign detect[W_LIFE]  = life_left_i < life_lim;
  assign detect[W_XENC]  = xenc_warn_s;
  assign detect[W_XCOM]  = xenc_run > xenc_lim;

  // mask bit of one suppresses detection
  always_comb begin
    for (int i = 0; i < NWARN; i++) begin
      raw[i] = detect[i] && !mask[MASK_POS[i]];
    end
  end

  // ----
  // latch bank and alarm sequencer
  // ----
  logic clr_req;
  assign clr_req = rst_req_s || tool_clr;

  swam_cfg_if cfg ();
  assign cfg.hold_time = hold_time;
  assign cfg.raw       = raw;
  assign cfg.clear     = clr_req;

  swam_latch_bank u_bank (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .sec_tick_i (sec_tick),
    .cfg        (cfg)
  );

  logic [2:0]  al_attr;
  logic [15:0] al_snap;
  swam_alarm_seq u_alarm (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .err_i        (err_i),
    .err_code_i   (err_code_i),
    .err_attr_i   (err_attr_i),
    .status_i     (status_i),
    .clr_req_i    (clr_req),
    .stop_done_i  (stop_done_i),
    .alarm_o      (alarm_output_line_o),
    .pwr_off_o    (pwr_off_o),
    .immed_stop_o (immed_stop_o),
    .seq_stop_o   (seq_stop_o),
    .code_o       (alarm_code_o),
    .attr_o       (al_attr),
    .snap_o       (al_snap),
    .hist_o       (hist_rec_o)
  );

  // ----
  // warning output lines
  // ----
  function automatic logic line_on(input logic [3:0] sel, input logic [NWARN-1:0] act);
    line_on = 1'b0;
    if (sel == SEL_ALL) line_on = |act;
    else if (sel <= NWARN) line_on = act[sel - 4'h1];
  endfunction

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      warning_line_one_o <= 1'b0;
      warning_line_two_o <= 1'b0;
    end else begin
      warning_line_one_o <= line_on(sel1, cfg.active);
      warning_line_two_o <= line_on(sel2, cfg.active);
    end
  end

  // ----
  // read path: one wait state, readdata stands when waitrequest drops
  // ----
  logic [31:0] rd_mux;
  assign avs_waitrequest_o = rd_en;
  always_comb begin
    case (widx)
      REG_SEL1:   rd_mux = {28'h0, sel1};
      REG_SEL2:   rd_mux = {28'h0, sel2};
      REG_HOLD:   rd_mux = {28'h0, hold_time};
      REG_MASK:   rd_mux = {21'h0, mask};
      REG_WSTAT:  rd_mux = {6'h0, raw, 6'h0, cfg.active};
      REG_ALARM:  rd_mux = {17'h0, al_attr, alarm_code_o, 1'b0, pwr_off_o, immed_stop_o, alarm_output_line_o};
      REG_SNAP:   rd_mux = {16'h0, al_snap};
      REG_CNTLIM: rd_mux = {16'h0, xenc_lim, enc_lim};
      REG_SETVAL: rd_mux = {16'h0, life_lim, temp_lim};
      default:    rd_mux = UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge clock_i) begin
    rd_ack <= !rst_i && rd_en;
    if (rst_i) avs_readdata_o <= '0;
    else if (rd_en) avs_readdata_o <= rd_mux;
  end

endmodule

// ### swam_chk.sv
// swam_chk: port assertions for swam_top
// assumes: bound to swam_top; one clock, sync reset
`timescale 1ns/1ns
module swam_chk (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        alarm_reset_i,
  input wire logic        err_i,
  input wire logic [7:0]  err_code_i,
  input wire logic [2:0]  err_attr_i,
  input wire logic        stop_done_i,
  input wire logic        alarm_output_line_o,
  input wire logic        pwr_off_o,
  input wire logic        immed_stop_o,
  input wire logic        seq_stop_o,
  input wire logic [7:0]  alarm_code_o,
  input wire logic        hist_rec_o
);
  // ----
  // alarm and bus properties
  // ----
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_entry; $rose(alarm_output_line_o); endsequence
  sequence s_clr; $rose(alarm_reset_i) && alarm_output_line_o && err_attr_i[1] && !err_i; endsequence
  property p_rise; $rose(err_i) && !alarm_output_line_o |-> ##[1:4] alarm_output_line_o; endproperty
  a_rise: assert property (p_rise) else $error("alarm late");
  property p_code; s_entry |-> ##[0:1] alarm_code_o == err_code_i; endproperty
  a_code: assert property (p_code) else $error("alarm code wrong");
  property p_immed; s_entry and err_attr_i[2] |-> immed_stop_o && pwr_off_o && !seq_stop_o; endproperty
  a_immed: assert property (p_immed) else $error("no immediate stop");
  property p_seq; s_entry and !err_attr_i[2] |-> seq_stop_o && !immed_stop_o; endproperty
  a_seq: assert property (p_seq) else $error("no sequenced stop");
  property p_seqend; seq_stop_o && stop_done_i |-> ##[1:3] (!seq_stop_o && pwr_off_o); endproperty
  a_seqend: assert property (p_seqend) else $error("stop not ended");
  property p_noclr; alarm_output_line_o && !err_attr_i[1] && !err_i |=> alarm_output_line_o; endproperty
  a_noclr: assert property (p_noclr) else $error("fixed alarm dropped");
  property p_clr; s_clr |-> ##[1:8] !alarm_output_line_o; endproperty
  a_clr: assert property (p_clr) else $error("alarm not cleared");
  property p_hist; hist_rec_o |-> err_attr_i[0] ##1 !hist_rec_o; endproperty
  a_hist: assert property (p_hist) else $error("history pulse wrong");
  property p_unmap; avs_read_i && avs_address_i[5:2] > 4'h9 |=> avs_readdata_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule

// ### swam_host.sv
// swam_host: host controller model driving run and alarm reset
// assumes: clr_go_i is a one-cycle request from the bench
`timescale 1ns/1ns
module swam_host (
  input  wire logic clock_i,
  input  wire logic clr_go_i,
  input  wire logic slow_i,
  output logic      run_o,
  output logic      alarm_reset_o
);
  // ----
  // clear sequence
  // ----
  logic [3:0] cnt = 4'h0;
  initial run_o = 1'h1;
  initial alarm_reset_o = 1'h0;
  // run drops before the reset pulse and returns after it
  always @(posedge clock_i) begin
    cnt <= clr_go_i ? (slow_i ? 4'hc : 4'h6) : cnt - 4'(cnt != 4'h0);
    run_o <= !clr_go_i && cnt == 4'h0;
    alarm_reset_o <= cnt != 4'h0 && cnt < 4'h5;
  end
endmodule

// ### swam_tb_top.sv
// swam_tb_top: self-checking bench for swam_top
// assumes: package, interface, design, host model and checker compiled first
`timescale 1ns/1ns
module swam_tb_top;
  import swam_pkg::*;
  // ----
  // signals, models and instances
  // ----
  localparam int SC = 20;
  logic        clock_i = 1'h0, rst_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0, vib_i = 1'h0;
  logic        fan_stopped_i = 1'h0, xenc_warn_i = 1'h0, err_i = 1'h0, stop_done_i = 1'h0, clr_go = 1'h0;
  logic        slow = 1'h0, run, alarm_reset_i, avs_waitrequest_o, warning_line_one_o, warning_line_two_o;
  logic        alarm_output_line_o, pwr_off_o, immed_stop_o, seq_stop_o, hist_rec_o;
  logic [5:0]  avs_address_i = 6'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd_v;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [9:0]  load_pm_i = 10'h0, regen_pm_i = 10'h0;
  logic [11:0] batt_mv_i = 12'hfff;
  logic [7:0]  enc_temp_i = 8'h0, life_left_i = 8'hff, err_code_i = 8'h0, alarm_code_o;
  logic [15:0] status_i = 16'h0, lf = 16'h14;
  logic [2:0]  err_attr_i = 3'h0;
  int          n_errors = 0, samples_checked = 0, i, s2;
  logic        ee = 1'h0, xe = 1'h0, fr = 1'h0;
  // 250 MHz clock; encoder frames every other cycle
  initial forever #2 clock_i = ~clock_i;
  always @(posedge clock_i) fr <= !fr;
  swam_top #(.SEC_CYC(SC), .FAN_CYC(10)) u_dut (.clock_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .load_pm_i, .regen_pm_i, .batt_mv_i,
    .enc_temp_i, .life_left_i, .enc_err_i(ee), .enc_frame_i(fr), .xenc_err_i(xe), .xenc_frame_i(fr), .vib_i,
    .fan_stopped_i, .xenc_warn_i, .alarm_reset_i, .err_i, .err_code_i, .err_attr_i, .status_i, .stop_done_i,
    .warning_line_one_o, .warning_line_two_o, .alarm_output_line_o, .pwr_off_o, .immed_stop_o, .seq_stop_o,
    .alarm_code_o, .hist_rec_o);
  swam_host u_host (.clock_i, .clr_go_i(clr_go), .slow_i(slow), .run_o(run), .alarm_reset_o(alarm_reset_i));
  // verdict and compare
  task automatic close_out();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] nx(input logic [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [1:0] obs(input int s);
    obs = (s != 0) ? {1'h0, alarm_output_line_o} : {warning_line_one_o, warning_line_two_o};
  endfunction
  // avalon-mm master: hold until waitrequest low, take data at that edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_i);
    avs_address_i <= {a, 2'h0};
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'h0) begin
      if (++k > 50) begin
        chk("waitrequest", 32'h0, 32'h1);
        close_out();
      end
      @(posedge clock_i);
    end
    rd_v = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'h0, a, 32'h0);
    chk(nm, e, rd_v);
  endtask
  // bounded wait, then fixed-length stand check
  task automatic wv(input int s, input logic [1:0] e, input int b);
    int k;
    for (k = 0; k < b && obs(s) !== e; k++) @(negedge clock_i);
    chk("wait_level", e, obs(s));
    if (obs(s) !== e) close_out();
  endtask
  task automatic st(input int s, input logic [1:0] e, input int n);
    repeat (n) begin
      @(negedge clock_i);
      chk("stand_level", e, obs(s));
    end
  endtask
  // cause of each warning at its boundary value
  task automatic cause(input int c, input logic on);
    @(posedge clock_i);
    case (c)
      W_OVL: load_pm_i <= on ? LOAD_WARN_PM : LOAD_WARN_PM - 10'h1;
      W_REGEN: regen_pm_i <= on ? LOAD_WARN_PM : LOAD_WARN_PM - 10'h1;
      W_BATT: batt_mv_i <= on ? BATT_WARN_MV : BATT_WARN_MV + 12'h1;
      W_FAN: fan_stopped_i <= on;
      W_ENC: ee <= on;
      W_ENCT: enc_temp_i <= on ? RST_TEMP + 8'h1 : RST_TEMP;
      W_VIB: vib_i <= on;
      W_LIFE: life_left_i <= on ? RST_LIFE - 8'h1 : RST_LIFE;
      W_XCOM: xe <= on;
      default: xenc_warn_i <= on;
    endcase
  endtask
  task automatic clr();
    @(posedge clock_i);
    clr_go <= 1'h1;
    slow <= lf[0];
    @(posedge clock_i);
    clr_go <= 1'h0;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'h0;
    rc(REG_SEL1, 32'h0, "sel1");
    rc(REG_HOLD, 32'h1, "hold");
    rc(REG_MASK, 32'h0, "mask");
    rc(REG_SETVAL, 32'h0a78, "setval");
    for (int j = 0; j < 3; j++) begin
      lf = nx(lf);
      wr(REG_SEL2, lf % 11);
      rc(REG_SEL2, lf % 11, "sel2");
      wr(REG_MASK, lf[10:0]);
      rc(REG_MASK, lf[10:0], "mask_rb");
    end
    wr(4'hc, 32'h5);
    rc(4'hc, 32'h0, "unmapped");
    wr(REG_MASK, 1 << MASK_POS[W_VIB]);
    wr(REG_SEL1, 32'h0);
    wr(REG_SEL2, 32'h7);
    cause(W_VIB, 1'h1);
    st(0, 2'h0, 10);
    cause(W_VIB, 1'h0);
    wr(REG_MASK, 32'h0);
    for (i = 0; i < NWARN; i++) begin
      lf = nx(lf);
      s2 = lf[0] ? 0 : (i + 2) % 11;
      wr(REG_SEL1, i + 1);
      wr(REG_SEL2, s2);
      cause(i, 1'h1);
      if (i == W_FAN) st(0, 2'h0, 6);
      wv(0, {1'h1, s2 == 0}, 40);
      rc(REG_WSTAT, 32'h10001 << i, "wstat");
      cause(i, 1'h0);
      if (i == W_BATT || i == W_LIFE) begin
        st(0, {1'h1, s2 == 0}, 3 * SC);
        clr();
      end
      wv(0, 2'h0, 3 * SC);
    end
    wr(REG_SEL1, 32'h1);
    wr(REG_SEL2, 32'h0);
    wr(REG_HOLD, 32'ha);
    cause(W_OVL, 1'h1);
    wv(0, 2'h3, 10);
    cause(W_OVL, 1'h0);
    st(0, 2'h3, 7 * SC);
    wv(0, 2'h0, 5 * SC);
    wr(REG_HOLD, 32'h0);
    cause(W_OVL, 1'h1);
    wv(0, 2'h3, 10);
    cause(W_OVL, 1'h0);
    st(0, 2'h3, 3 * SC);
    // clearable immediate alarm, status changes after entry
    lf = nx(lf);
    status_i <= lf;
    err_code_i <= lf[7:0];
    err_attr_i <= 3'h7;
    repeat (3) @(posedge clock_i);
    err_i <= 1'h1;
    repeat (3) @(posedge clock_i);
    status_i <= ~lf;
    rc(REG_SNAP, {16'h0, lf}, "snap");
    rc(REG_ALARM, {17'h0, 3'h7, lf[7:0], 4'h5}, "alarm");
    chk("code", {24'h0, lf[7:0]}, {24'h0, alarm_code_o});
    @(posedge clock_i);
    err_i <= 1'h0;
    clr();
    wv(1, 2'h0, 30);
    chk("run", 32'h0, {31'h0, run});
    wv(0, 2'h0, 10);
    // fixed alarm with sequenced stop, then reset in mid-run
    @(posedge clock_i);
    err_attr_i <= 3'h0;
    err_code_i <= ~lf[7:0];
    err_i <= 1'h1;
    wv(1, 2'h1, 10);
    chk("seq_stop", 32'h1, {31'h0, seq_stop_o});
    @(posedge clock_i);
    stop_done_i <= 1'h1;
    err_i <= 1'h0;
    st(1, 2'h1, 4);
    rc(REG_ALARM, {17'h0, 3'h0, ~lf[7:0], 4'h5}, "alarm_seq");
    clr();
    st(1, 2'h1, 30);
    @(posedge clock_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'h0;
    st(1, 2'h0, 2);
    // clearable alarm cleared by service command
    @(posedge clock_i);
    err_attr_i <= 3'h2;
    err_i <= 1'h1;
    wv(1, 2'h1, 10);
    @(posedge clock_i);
    err_i <= 1'h0;
    wr(REG_CMD, 32'h1);
    wv(1, 2'h0, 20);
    close_out();
  end
  // watchdog
  initial begin
    #200000;
    chk("watchdog", 32'h0, 32'h1);
    close_out();
  end
endmodule
bind swam_top swam_chk u_chk (.clock_i, .rst_i, .avs_address_i, .avs_read_i, .avs_readdata_o, .alarm_reset_i, .err_i,
  .err_code_i, .err_attr_i, .stop_done_i, .alarm_output_line_o, .pwr_off_o, .immed_stop_o, .seq_stop_o, .alarm_code_o,
  .hist_rec_o);
